// ==== hw/jtp_pkg.sv ====
// shared constants, types and helpers of the four-wire test port block
// assumes one core clock; tap pins arrive asynchronous and are filtered inside
package jtp_pkg;

   // instruction codes, four bits wide
   localparam logic [3:0] IR_EXTEST    = 4'h0;
   localparam logic [3:0] IR_IDCODE    = 4'h1;
   localparam logic [3:0] IR_SAMPLE    = 4'h2;
   localparam logic [3:0] IR_PROG      = 4'h5; // programming command path
   localparam logic [3:0] IR_HIDDEN_A  = 4'h8; // hidden_debug_op_a: message channel
   localparam logic [3:0] IR_HIDDEN_B  = 4'h9; // hidden_debug_op_b: access enable
   localparam logic [3:0] IR_HIDDEN_C  = 4'hA; // hidden_debug_op_c
   localparam logic [3:0] IR_HIDDEN_D  = 4'hB; // hidden_debug_op_d
   localparam logic [3:0] IR_CORE_RST  = 4'hC; // core_reset_instruction
   localparam logic [3:0] IR_BYPASS    = 4'hF;
   localparam logic [3:0] IR_CAPTURE   = 4'h1; // fixed capture pattern

   // data register lengths
   localparam int ID_LEN   = 32;
   localparam int MSG_LEN  = 9;
   localparam int ACC_LEN  = 1;
   localparam int PRG_LEN  = 4;
   localparam int RST_LEN  = 1;
   localparam int BYP_LEN  = 1;

   // programming commands
   localparam logic [3:0] PCMD_ERASE    = 4'h1;
   localparam logic [3:0] PCMD_FLASH    = 4'h2;
   localparam logic [3:0] PCMD_EEPROM   = 4'h3;
   localparam logic [3:0] PCMD_FUSE     = 4'h4;
   localparam logic [3:0] PCMD_LOCK     = 4'h5;
   localparam logic [3:0] PCMD_DBG_FUSE = 4'h6;

   // reset values
   localparam logic [3:0] LINK_IDLE = 4'h5; // tck 0, tms 1, tdi 0, rst_n 1
   localparam logic [7:0] MSG_RST   = 8'h00;

   typedef enum {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
      TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
      TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
   } jtp_tap_t;

   typedef enum {DR_BYP, DR_ID, DR_BSC, DR_RST, DR_MSG, DR_ACC, DR_PRG} jtp_dr_t;

   // tap pins plus external reset pin
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic rst_n;
   } jtp_link_t;

   // processor access to the shared message location
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } jtp_cpu_req_t;

   // sixteen-state controller step, taken on a rising tck
   function automatic jtp_tap_t tap_next(jtp_tap_t s, logic m);
      case (s)
         TAP_RESET:  tap_next = m ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
         TAP_PA_DR:  tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: tap_next = m ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
         TAP_PA_IR:  tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         default:    tap_next = TAP_RESET;
      endcase
   endfunction

endpackage

// ==== hw/jtp_fifo.sv ====
// flip-flop fifo with valid/ready on both sides
// assumes depth is a power of two; one clock, synchronous reset
`timescale 1ns/1ps
module jtp_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input  logic         clk,
   input  logic         rst,
   input  logic         in_valid,
   input  logic [W-1:0] in_data,
   output logic         in_ready,
   output logic         out_valid,
   output logic [W-1:0] out_data,
   input  logic         out_ready
);
   import jtp_pkg::*;

   localparam int AW = $clog2(D);

   logic [W-1:0] mem_r [D];   // storage
   logic [AW-1:0] wp_r;       // write index
   logic [AW-1:0] rp_r;       // read index
   logic [AW:0]   cnt_r;      // fill level
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_r != (AW+1)'(D)); // full once the level reaches depth
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   ////////////////////////////////////////////////////////////////////
   // storage, no reset needed on data
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   // pointers wrap naturally at the power-of-two depth
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'h1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'h1;
         end
      end
   end

   // fill level
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (push && !pop) begin
         cnt_r <= cnt_r + 1'h1;
      end else if (pop && !push) begin
         cnt_r <= cnt_r - 1'h1;
      end
   end

   fifo_bound_a: assert property (@(posedge clk) disable iff (rst) cnt_r <= (AW+1)'(D))
      else $error("fifo level above depth");

endmodule

// ==== hw/jtp_port.sv ====
// four-wire test access port with boundary scan and debug message channel
// assumes tap pins and reset pin asynchronous, fuses and cpu bus on clk
// What this block does
// - codes 8 and 9 reach hidden debug
// - port alone programs flash, eeprom, fuses, locks
// - locked part refuses debug fuse until erase
// - cpu write stores byte, sets dirty
// - cpu read gives dirty plus seven bits
// - shared address reaches channel only when enabled
// - idcode is default after tap reset
// - idcode, bypass, sample, extest, core reset
// - core reset floats pin outputs at once, except under extest
// - core reset from pin or reset instruction
// - extest drives latched values immediately
// - sample snapshots pins during normal operation
// - scan needs clk running, tck below a quarter of its rate
// - chain covers digital pins and analog edge
// - bypass stage cleared on capture
`timescale 1ns/1ps
module jtp_port #(
   parameter int          NPIN     = 8,
   parameter int          NANA     = 2,
   parameter int          MSG_DEPTH = 32,
   parameter logic [31:0] ID_VALUE = 32'h0000_0001 // arbitrary, lsb fixed at one
) (
   input  logic                 clk,
   input  logic                 rst,
   input  jtp_pkg::jtp_link_t   link_in,
   output logic                 tdo,
   output logic                 tdo_oe,
   input  logic                 test_port_enable_fuse,
   input  logic                 test_port_disable_bit,
   input  logic                 debug_enable_fuse,
   input  logic                 lock_bit_one,
   input  logic                 lock_bit_two,
   input  jtp_pkg::jtp_cpu_req_t cpu_req,
   input  logic                 cpu_msg_sel,
   output logic                 cpu_wr_ready,
   output logic [7:0]           cpu_rdata,
   output logic                 std_io_wr,
   output logic                 std_io_rd,
   input  logic [7:0]           std_io_rdata,
   output logic                 core_reset,
   input  logic [NPIN-1:0]      core_out,
   input  logic [NPIN-1:0]      core_oe,
   input  logic [NPIN-1:0]      pin_in,
   output logic [NPIN-1:0]      pin_out,
   output logic [NPIN-1:0]      pin_oe,
   input  logic [NANA-1:0]      ana_core,
   output logic [NANA-1:0]      ana_ctl,
   output logic [3:0]           prog_cmd,
   output logic                 prog_stb
);
   import jtp_pkg::*;

   localparam int SW  = 4 + NPIN;                 // synchronised bits
   localparam int BSL = 3 * NPIN + NANA;          // boundary chain length
   localparam int DW  = (BSL > ID_LEN) ? BSL : ID_LEN;

   logic [SW-1:0]  s1_r, s2_r, s3_r;  // three-stage pin synchroniser
   logic [SW-1:0]  f_r;               // agreed level
   jtp_link_t      link_f;            // filtered tap pins
   logic [NPIN-1:0] pin_f;            // filtered pad levels
   logic           tck_q_r;           // previous tck for edges
   logic           tck_rise, tck_fall;
   logic           port_act;          // tap allowed to run
   jtp_tap_t       state_r;           // controller state
   logic [3:0]     ir_r, ir_sh_r;     // instruction and its shifter
   jtp_dr_t        dr_sel;            // selected data register
   logic [DW-1:0]  dr_sh_r, dr_cap, dr_shift_nxt;
   logic [BSL-1:0] upd_r;             // boundary update latches
   logic           rst_dr_r;          // reset data register
   logic           acc_en_r;          // debugger opened the channel
   logic [7:0]     msg_r;             // message byte
   logic           dirty_r;           // register_dirty_flag
   logic           locked, ocd_ok, extest, route;
   logic           upd_dr, core_rst_nxt, dbg_clr;
   logic           erased_r, refused_r;
   logic           tdo_r, tdo_oe_r, core_reset_r, prog_stb_r;
   logic [3:0]     prog_cmd_r;
   logic [7:0]     cpu_rdata_r;
   logic [NPIN-1:0] pin_out_r, pin_oe_r;
   logic [NANA-1:0] ana_ctl_r;
   logic           f_valid, f_pop, push;
   logic [7:0]     f_data;

   // length of each data register, used to place tdi during shift
   function automatic int dr_len(jtp_dr_t d);
      case (d)
         DR_ID:   dr_len = ID_LEN;
         DR_BSC:  dr_len = BSL;
         DR_RST:  dr_len = RST_LEN;
         DR_MSG:  dr_len = MSG_LEN;
         DR_ACC:  dr_len = ACC_LEN;
         DR_PRG:  dr_len = PRG_LEN;
         default: dr_len = BYP_LEN;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // pin synchroniser: a change counts once stages two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r <= {{NPIN{1'h0}}, LINK_IDLE};
         s2_r <= {{NPIN{1'h0}}, LINK_IDLE};
         s3_r <= {{NPIN{1'h0}}, LINK_IDLE};
         f_r  <= {{NPIN{1'h0}}, LINK_IDLE};
         tck_q_r <= 1'h0;
      end else begin
         s1_r <= {pin_in, link_in};
         s2_r <= s1_r;
         s3_r <= s2_r;
         f_r  <= (s2_r & s3_r) | (f_r & (s2_r | s3_r));
         tck_q_r <= f_r[3];
      end
   end

   assign link_f   = jtp_link_t'(f_r[3:0]);
   assign pin_f    = f_r[SW-1:4];
   // tck sampled by clk: it must stay below a quarter of the clk rate
   assign tck_rise = link_f.tck & ~tck_q_r;
   assign tck_fall = ~link_f.tck & tck_q_r;
   assign port_act = test_port_enable_fuse & ~test_port_disable_bit;
   assign locked   = lock_bit_one | lock_bit_two;
   assign ocd_ok   = debug_enable_fuse & ~locked;
   assign extest   = port_act & (ir_r == IR_EXTEST);

   ////////////////////////////////////////////////////////////////////
   // controller: tms taken on rising tck, held in reset while disabled
   always_ff @(posedge clk) begin
      if (rst || !port_act) begin
         state_r <= TAP_RESET;
      end else if (tck_rise) begin
         state_r <= tap_next(state_r, link_f.tms);
      end
   end

   // instruction register, idcode whenever the controller is in reset
   always_ff @(posedge clk) begin
      if (rst || state_r == TAP_RESET) begin
         ir_r    <= IR_IDCODE;
         ir_sh_r <= IR_CAPTURE;
      end else if (tck_rise && state_r == TAP_CAP_IR) begin
         ir_sh_r <= IR_CAPTURE;
      end else if (tck_rise && state_r == TAP_SH_IR) begin
         ir_sh_r <= {link_f.tdi, ir_sh_r[3:1]};
      end else if (tck_fall && state_r == TAP_UPD_IR) begin
         ir_r <= ir_sh_r;
      end
   end

   // decode: hidden codes need the debug system, unknown codes bypass
   always_comb begin
      case (ir_r)
         IR_EXTEST, IR_SAMPLE: dr_sel = DR_BSC;
         IR_IDCODE:   dr_sel = DR_ID;
         IR_CORE_RST: dr_sel = DR_RST;
         IR_PROG:     dr_sel = DR_PRG;
         IR_HIDDEN_A: dr_sel = ocd_ok ? DR_MSG : DR_BYP;
         IR_HIDDEN_B: dr_sel = ocd_ok ? DR_ACC : DR_BYP;
         default:     dr_sel = DR_BYP;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // capture values per register
   always_comb begin
      dr_cap = '0;
      case (dr_sel)
         DR_ID:   dr_cap[ID_LEN-1:0] = ID_VALUE;
         // pads, core outputs, core enables, analog controls
         DR_BSC:  dr_cap[BSL-1:0] = {ana_core, core_oe, core_out, pin_f};
         DR_RST:  dr_cap[0] = rst_dr_r;
         DR_MSG:  dr_cap[MSG_LEN-1:0] = {dirty_r, msg_r};
         DR_ACC:  dr_cap[0] = acc_en_r;
         DR_PRG:  dr_cap[PRG_LEN-1:0] = {2'h0, refused_r, erased_r};
         default: dr_cap[0] = 1'h0;
      endcase
   end

   // tdi enters at the top bit of the selected length
   always_comb begin
      dr_shift_nxt = {1'h0, dr_sh_r[DW-1:1]};
      dr_shift_nxt[dr_len(dr_sel)-1] = link_f.tdi;
   end

   // shared data shifter
   always_ff @(posedge clk) begin
      if (rst) begin
         dr_sh_r <= '0;
      end else if (tck_rise && state_r == TAP_CAP_DR) begin
         dr_sh_r <= dr_cap;
      end else if (tck_rise && state_r == TAP_SH_DR) begin
         dr_sh_r <= dr_shift_nxt;
      end
   end

   assign upd_dr = tck_fall & (state_r == TAP_UPD_DR);

   // boundary latches, loaded by both sample and extest (preload)
   always_ff @(posedge clk) begin
      if (rst) begin
         upd_r <= '0;
      end else if (upd_dr && dr_sel == DR_BSC) begin
         upd_r <= dr_sh_r[BSL-1:0];
      end
   end

   // single-bit registers written by update
   always_ff @(posedge clk) begin
      if (rst) begin
         rst_dr_r <= 1'h0;
         acc_en_r <= 1'h0;
      end else if (upd_dr) begin
         if (dr_sel == DR_RST) begin
            rst_dr_r <= dr_sh_r[0];
         end
         if (dr_sel == DR_ACC) begin
            acc_en_r <= dr_sh_r[0];
         end
      end
   end

   // tdo changes on falling tck, driven only while shifting
   always_ff @(posedge clk) begin
      if (rst || !port_act) begin
         tdo_r    <= 1'h0;
         tdo_oe_r <= 1'h0;
      end else if (tck_fall) begin
         tdo_r    <= (state_r == TAP_SH_IR) ? ir_sh_r[0] : dr_sh_r[0];
         tdo_oe_r <= (state_r == TAP_SH_IR) || (state_r == TAP_SH_DR);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // programming path: needs only the four tap pins, no high voltage
   always_ff @(posedge clk) begin
      if (rst) begin
         prog_cmd_r <= 4'h0;
         prog_stb_r <= 1'h0;
         erased_r   <= 1'h0;
         refused_r  <= 1'h0;
      end else begin
         prog_stb_r <= 1'h0;
         if (upd_dr && dr_sel == DR_PRG) begin
            prog_cmd_r <= dr_sh_r[3:0];
            // a locked part keeps its debug fuse until erased
            if (dr_sh_r[3:0] == PCMD_DBG_FUSE && locked && !erased_r) begin
               refused_r <= 1'h1;
            end else begin
               prog_stb_r <= 1'h1;
               refused_r  <= 1'h0;
            end
            if (dr_sh_r[3:0] == PCMD_ERASE) begin
               erased_r <= 1'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // message channel: routed only when fuse and debugger allow
   assign route     = cpu_msg_sel & debug_enable_fuse & acc_en_r;
   assign push      = cpu_req.wr & route;
   assign std_io_wr = cpu_req.wr & cpu_msg_sel & ~route;
   assign std_io_rd = cpu_req.rd & cpu_msg_sel & ~route;
   // debugger update with bit zero set clears dirty after its read
   assign dbg_clr   = upd_dr & (dr_sel == DR_MSG) & dr_sh_r[0];
   // next byte moves up when the slot is free; set beats clear
   assign f_pop     = f_valid & (~dirty_r | dbg_clr);

   jtp_fifo #(.W(8), .D(MSG_DEPTH)) msg_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (push),
      .in_data   (cpu_req.wdata),
      .in_ready  (cpu_wr_ready),
      .out_valid (f_valid),
      .out_data  (f_data),
      .out_ready (f_pop)
   );

   // message byte and dirty flag
   always_ff @(posedge clk) begin
      if (rst) begin
         msg_r   <= MSG_RST;
         dirty_r <= 1'h0;
      end else if (f_pop) begin
         msg_r   <= f_data;
         dirty_r <= 1'h1;
      end else if (dbg_clr) begin
         dirty_r <= 1'h0;
      end
   end

   // read data: dirty in the top bit
   always_ff @(posedge clk) begin
      if (rst) begin
         cpu_rdata_r <= 8'h00;
      end else if (cpu_req.rd && cpu_msg_sel) begin
         cpu_rdata_r <= route ? {dirty_r, msg_r[6:0]} : std_io_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // core reset from pin or reset instruction
   assign core_rst_nxt = ~link_f.rst_n | (ir_r == IR_CORE_RST & rst_dr_r);

   always_ff @(posedge clk) begin
      if (rst) begin
         core_reset_r <= 1'h1;
      end else begin
         core_reset_r <= core_rst_nxt;
      end
   end

   // pad drivers: extest overrides, reset floats the outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_out_r <= '0;
         pin_oe_r  <= '0;
         ana_ctl_r <= '0;
      end else if (extest) begin
         pin_out_r <= upd_r[2*NPIN-1:NPIN];
         pin_oe_r  <= upd_r[3*NPIN-1:2*NPIN];
         ana_ctl_r <= upd_r[BSL-1:3*NPIN];
      end else begin
         pin_out_r <= core_out;
         pin_oe_r  <= core_rst_nxt ? '0 : core_oe;
         ana_ctl_r <= ana_core;
      end
   end

   assign tdo        = tdo_r;
   assign tdo_oe     = tdo_oe_r;
   assign core_reset = core_reset_r;
   assign pin_out    = pin_out_r;
   assign pin_oe     = pin_oe_r;
   assign ana_ctl    = ana_ctl_r;
   assign prog_cmd   = prog_cmd_r;
   assign prog_stb   = prog_stb_r;
   assign cpu_rdata  = cpu_rdata_r;

   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   idcode_dflt_a: assert property (state_r == TAP_RESET |=> ir_r == IR_IDCODE) else $error("ir not idcode");
   port_off_a: assert property (!port_act |=> state_r == TAP_RESET && !tdo_oe) else $error("port not held");
   hidden_gate_a: assert property (!ocd_ok |-> dr_sel != DR_MSG && dr_sel != DR_ACC) else $error("hidden open");
   unknown_byp_a: assert property (ir_r inside {4'h3, 4'h4, 4'h6, 4'h7, 4'hA, 4'hB, 4'hD, 4'hE} |-> dr_sel == DR_BYP) else $error("no bypass");
   byp_clear_a: assert property (tck_rise && state_r == TAP_CAP_DR && dr_sel == DR_BYP |=> !dr_sh_r[0]) else $error("bypass set");
   fuse_lock_a: assert property (prog_stb && prog_cmd == PCMD_DBG_FUSE |-> !locked || erased_r) else $error("fuse unlocked");
   dirty_set_a: assert property (f_pop |=> dirty_r && msg_r == $past(f_data)) else $error("dirty not set");
   read_fmt_a: assert property (cpu_req.rd && route |=> cpu_rdata == {$past(dirty_r), $past(msg_r[6:0])}) else $error("bad read");
   route_a: assert property (cpu_req.wr && cpu_msg_sel && !route |-> std_io_wr && !push) else $error("bad route");
   core_rst_a: assert property (!link_f.rst_n |=> core_reset ##1 core_reset || link_f.rst_n) else $error("no reset");
   float_a: assert property (core_rst_nxt && !extest |=> pin_oe == '0) else $error("pins driven");
   extest_a: assert property (extest |=> pin_out == $past(upd_r[2*NPIN-1:NPIN])) else $error("extest late");

   extest_c: cover property (extest ##1 pin_oe != '0);
   msg_c: cover property (f_pop ##[1:200] dbg_clr);
   refuse_c: cover property (upd_dr && dr_sel == DR_PRG ##1 refused_r);

endmodule

// ==== test/jtp_ctl_model.sv ====
// tap controller model: drives tck, tms and tdi, reads tdo
// assumes the port oversamples tck with its own core clock
`timescale 1ns/1ps
module jtp_ctl_model (
   output logic tck,
   output logic tms,
   output logic tdi,
   input  logic tdo
);
   // link clock stands low between frames
   initial {tck, tms, tdi} = 3'b010;
   // one 80 ns link cycle; tdo is read late in the high phase
   // because the port answers some 5 core clocks after a fall
   task automatic tick(input logic m, input logic d, output logic q);
      {tms, tdi} = {m, d};
      #40 tck = 1'b1;
      #40 q = tdo;
      tck = 1'b0;
   endtask
   // five ones force test-logic-reset, one zero reaches idle
   task automatic park();
      logic q;
      repeat (5) tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
   endtask
   // idle to idle scan of n bits, lsb first
   task automatic scan(input bit ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = '0;
      tick(1'b1, 1'b0, q);
      if (ir) tick(1'b1, 1'b0, q);
      repeat (2) tick(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
   endtask
endmodule

// ==== test/tb_jtag_boundary_scan_debug_port.sv ====
// bench of the test port: tap scans through the model, cpu strobes direct
// assumes 125 MHz core clock; the model paces the 80 ns link clock
`timescale 1ns/1ps
module tb_jtag_boundary_scan_debug_port;
   import jtp_pkg::*;
   localparam logic [31:0] ID = 32'h1234_5671; // arbitrary
   localparam logic [11:0] BYP_IRS = 12'hF38; // codes that must land on bypass
   logic clk, rst, rst_n, tck, tms, tdi, tdo, tdo_oe, en, dis, dbg, lk1, wr, rd, sel, s, ok;
   logic cwr_rdy, iow, ior, core_reset, stb;
   logic [7:0] wd, q8, rdata, pin, pout, poe;
   logic [1:0] ana;
   logic [3:0] pcmd, lastc;
   logic [31:0] q;
   int miscompares, samples_checked, n, stbs;
   jtp_link_t link;
   jtp_cpu_req_t req;
   assign link = {tck, tms, tdi, rst_n};
   assign req = {wr, rd, wd};
   ////////////////////////////////////////////////////////////////
   // a released tdo shows the inverse, so a read outside shift cannot pass
   jtp_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_oe ? tdo : ~tdo));
   jtp_port #(.ID_VALUE(ID)) DUT (
      .clk(clk), .rst(rst), .link_in(link), .tdo(tdo), .tdo_oe(tdo_oe),
      .test_port_enable_fuse(en), .test_port_disable_bit(dis), .debug_enable_fuse(dbg),
      .lock_bit_one(lk1), .lock_bit_two(1'b0), .cpu_req(req), .cpu_msg_sel(sel),
      .cpu_wr_ready(cwr_rdy), .cpu_rdata(rdata), .std_io_wr(iow), .std_io_rd(ior),
      .std_io_rdata(8'h5A), .core_reset(core_reset), .core_out(8'h0F), .core_oe(8'hFF),
      .pin_in(pin), .pin_out(pout), .pin_oe(poe), .ana_core(2'b01), .ana_ctl(ana),
      .prog_cmd(pcmd), .prog_stb(stb));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // programming strobes and tdo drive seen by the bench
   always @(posedge clk) begin
      if (stb) begin
         stbs++;
         lastc = pcmd;
      end
      if (tdo_oe) ok = 1'b1;
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // instruction load; ir capture pattern comes back
   task automatic ir(input logic [3:0] c);
      ctl.scan(1'b1, 4, {28'h0, c}, q);
      chk(q, 32'h1);
   endtask
   // one cpu access at the shared location; s is the ordinary strobe
   task automatic cpu(input logic w, input logic [7:0] d);
      @(posedge clk);
      #1 {wr, rd, wd, sel} = {w, !w, d, 1'b1};
      #1 s = w ? iow : ior;
      @(posedge clk);
      #1 {wr, rd} = 2'b00;
      q8 = rdata;
   endtask
   initial begin
      #600000;
      miscompares++;
      report_and_stop();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      {rst, rst_n, en, dis, dbg, lk1, wr, rd, sel, wd, pin} = {9'h1C0, 16'h0};
      {miscompares, samples_checked, stbs, ok} = '0;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      ctl.park();
      ctl.scan(1'b0, 32, 32'h0, q);
      chk(q, ID);
      for (int i = 0; i < 3; i++) begin
         ir(BYP_IRS[4*i +: 4]);
         ctl.scan(1'b0, 2, 32'h3, q);
         chk(q, 32'h2);
      end
      chk(ok, 1'b1);
      dis = 1'b1;
      ok = 1'b0;
      ctl.scan(1'b1, 4, 32'hF, q);
      chk(ok, 1'b0);
      {dis, en} = 2'b00;
      ctl.scan(1'b1, 4, 32'hF, q);
      chk(ok, 1'b0);
      en = 1'b1;
      // the held controller sits in reset; walk it back to idle
      ctl.park();
      $display("scan basics done");
      pin = 8'h3C;
      ir(IR_SAMPLE);
      ctl.scan(1'b0, 26, {6'h0, 2'b10, 8'hF0, 8'hA5, 8'h00}, q);
      chk(q[7:0], 8'h3C);
      chk(pout, 8'h0F);
      ir(IR_EXTEST);
      chk({ana, poe, pout}, {2'b10, 8'hF0, 8'hA5});
      ctl.park();
      ir(IR_CORE_RST);
      ctl.scan(1'b0, 1, 32'h1, q);
      chk({core_reset, poe}, 9'h100);
      ctl.scan(1'b0, 1, 32'h0, q);
      chk({core_reset, poe}, 9'h0FF);
      rst_n = 1'b0;
      repeat (6) @(posedge clk);
      #1 chk({core_reset, poe}, 9'h100);
      rst_n = 1'b1;
      $display("boundary and reset done");
      cpu(1'b1, 8'h11);
      chk(s, 1'b1);
      cpu(1'b0, 8'h00);
      chk({s, q8}, 9'h15A);
      dbg = 1'b1;
      ir(IR_HIDDEN_B);
      ctl.scan(1'b0, 1, 32'h1, q);
      @(posedge clk);
      #1 {wr, sel, n} = {2'b11, 32'h0};
      for (int k = 0; k < 40; k++) begin
         wd = 8'h80 ^ n[7:0];
         #6 ok = cwr_rdy;
         @(posedge clk);
         #1 n += ok;
      end
      wr = 1'b0;
      chk(n, 33);
      cpu(1'b0, 8'h00);
      chk({s, q8}, 9'h080);
      ir(IR_HIDDEN_A);
      for (int i = 0; i < 33; i++) begin
         ctl.scan(1'b0, 9, 32'h1, q);
         chk(q, {23'h1, 8'h80 ^ i[7:0]});
      end
      cpu(1'b0, 8'h00);
      chk(q8, 8'h20);
      $display("message channel done");
      lk1 = 1'b1;
      ir(IR_PROG);
      ctl.scan(1'b0, 4, {28'h0, PCMD_DBG_FUSE}, q);
      chk(stbs, 0);
      for (int c = 1; c < 7; c++) begin
         ctl.scan(1'b0, 4, c, q);
         chk(lastc, c[3:0]);
         if (c == 1) chk(q, 32'h2);
      end
      chk(stbs, 6);
      $display("programming done");
      report_and_stop();
   end
endmodule
